// ==== common/aswc_pkg.sv ====
`default_nettype none
package aswc_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] ASWC_CFG_OFF   = 8'hF0; // sleep/wake configuration
  localparam logic [7:0] ASWC_CTRL_OFF  = 8'hF4; // sleep type and sleep enable
  localparam logic [7:0] ASWC_STAT_OFF  = 8'hF8; // sticky event flags
  localparam logic [7:0] ASWC_WEN_OFF   = 8'hFC; // wakeup event enables

  // configuration field positions
  localparam int ASWC_CFG_SLP_BIT = 0; // sleep function select
  localparam int ASWC_CFG_WAK_BIT = 1; // wake function select

  // control field positions
  localparam int ASWC_CTRL_TYPE_LSB = 0; // sleep type field, low bit
  localparam int ASWC_CTRL_TYPE_W   = 3; // sleep type field width
  localparam int ASWC_CTRL_GO_BIT   = 7; // sleep enable, write one

  // status field positions
  localparam int ASWC_STAT_SMI_BIT = 0; // sleep request smi status
  localparam int ASWC_STAT_WAK_BIT = 1; // wake status

  // values after reset
  localparam logic [7:0] ASWC_CFG_RST  = 8'h00; // configuration after reset
  localparam logic [2:0] ASWC_TYPE_RST = 3'h0;  // sleep type after reset
  localparam logic       ASWC_PWR_RST  = 1'h1;  // power-on request idles high

  // configuration register content
  typedef struct packed {
    logic wake_function_select;  // 1: enabled wakeups also set wake status
    logic sleep_function_select; // 1: sleep request becomes an smi
  } aswc_cfg_type;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        sel;    // psel
    logic        enable; // penable
    logic        write;  // pwrite
    logic [7:0]  addr;   // byte address, low bits
    logic [31:0] wdata;  // write data
  } aswc_apb_req_type;
endpackage
`default_nettype wire

// ==== logic/aswc_top.sv ====
`default_nettype none
module aswc_top
  import aswc_pkg::*;
#(
  parameter int WAKE_N = 8 // number of wakeup event inputs
) (
  input  wire logic              clock_in,               // 20 mhz system clock
  input  wire logic              rst_in,                 // synchronous reset, high
  input  wire logic              psel_in,                // apb select
  input  wire logic              penable_in,             // apb access phase
  input  wire logic              pwrite_in,              // apb direction, 1 write
  input  wire logic [7:0]        paddr_in,               // apb byte address
  input  wire logic [31:0]       pwdata_in,              // apb write data
  output logic      [31:0]       prdata_out,             // apb read data
  output logic                   pready_out,             // apb ready
  output logic                   pslverr_out,            // apb error, unmapped
  input  wire logic              power_on_request_n_in,  // power-on request, low
  input  wire logic [WAKE_N-1:0] wake_event_in,          // wakeup event levels
  output logic                   sleep_start_out,        // pulse: begin sleep
  output logic      [2:0]        sleep_type_out,         // sleep state to enter
  output logic                   smi_out,                // smi request level
  output logic                   wake_status_out         // sticky wake status
);

  // the block answers four words on the bus: configuration, control,
  // status and wakeup enables; every other word is refused with an error
  // so that a stray write from software can never reach the sleep path
  // address match used by decode and readback
  function automatic logic aswc_hit(input logic [7:0] addr, input logic [7:0] off);
    aswc_hit = (addr[7:2] == off[7:2]);
  endfunction

  // all state lives in the one clock domain; the battery-side reset
  // arrives as rst_in, so every flop below resets on it, pwr_prev_q to one and the rest to zero
  // registers
  aswc_cfg_type      cfg_q;       // sleep/wake configuration
  logic [2:0]        type_q;      // programmed sleep type
  logic              smi_stat_q;  // sleep request smi status
  logic              wake_q;      // wake status
  logic [WAKE_N-1:0] wen_q;       // wakeup enables
  logic              pwr_prev_q;  // last power-on request level
  logic              pready_q;    // ready flop
  logic              pslverr_q;   // error flop
  logic [31:0]       prdata_q;    // read data flop
  logic              start_q;     // sleep start pulse
  logic              smi_q;       // smi output flop

  // the pins are gathered once so the decode reads one carrier
  // and not five loose inputs
  // bus request bundle
  aswc_apb_req_type  req_w;       // request as one carrier
  assign req_w = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                   addr: paddr_in, wdata: pwdata_in};

  // a write lands only at the edge that ends the access phase, never in
  // setup; a master that stretches its setup cannot write twice
  // the low two address bits are ignored, each register is one word
  // decode: the transfer completes at the edge where ready is seen
  wire setup_w    = req_w.sel & ~req_w.enable;          // setup cycle
  wire done_w     = req_w.sel & req_w.enable & pready_q; // access end edge
  wire wr_w       = done_w & req_w.write;               // write takes effect
  wire hit_cfg_w  = aswc_hit(req_w.addr, ASWC_CFG_OFF);  // config selected
  wire hit_ctrl_w = aswc_hit(req_w.addr, ASWC_CTRL_OFF); // control selected
  wire hit_stat_w = aswc_hit(req_w.addr, ASWC_STAT_OFF); // status selected
  wire hit_wen_w  = aswc_hit(req_w.addr, ASWC_WEN_OFF);  // enables selected
  wire mapped_w   = hit_cfg_w | hit_ctrl_w | hit_stat_w | hit_wen_w;

  // one strobe per register keeps each flop's enable a single gate,
  // which is cheap and easy to follow in a waveform
  // write strobes per register
  wire wr_cfg_w   = wr_w & hit_cfg_w;  // config write
  wire wr_ctrl_w  = wr_w & hit_ctrl_w; // control write
  wire wr_stat_w  = wr_w & hit_stat_w; // status write, one clears
  wire wr_wen_w   = wr_w & hit_wen_w;  // enables write

  // bit 7 of control is a command, not storage: it reads back zero, so a
  // read-modify-write of the sleep type cannot start sleep by accident
  // software request to sleep: a one in the sleep enable bit
  wire slp_wr_w   = wr_ctrl_w & req_w.wdata[ASWC_CTRL_GO_BIT];

  // only two bits are kept; the thirty reserved bits have no flop at all,
  // so they read zero and cannot be set by any write
  // a select written now steers requests from the next cycle on
  // configuration next value, reserved bits never stored
  aswc_cfg_type cfg_d;
  assign cfg_d = wr_cfg_w ? aswc_cfg_type'({req_w.wdata[ASWC_CFG_WAK_BIT],
                                           req_w.wdata[ASWC_CFG_SLP_BIT]}) : cfg_q;

  // sleep type follows each control write
  wire [2:0] type_d = wr_ctrl_w ?
                      req_w.wdata[ASWC_CTRL_TYPE_LSB +: ASWC_CTRL_TYPE_W] : type_q;

  // the select is taken as it stood before this write; a write of config
  // and control in one transfer is impossible, so no ordering hazard
  // limitation: two sleep requests need two bus transfers, one per pulse
  // sleep start only when the request is not diverted to an smi
  wire start_d = slp_wr_w & ~cfg_q.sleep_function_select;

  // the status is set whatever the select holds, so software can poll it
  // even with the smi masked; a clear that meets a new request loses,
  // because dropping a request is worse than reporting one twice
  // smi status: set on any sleep enable write, set wins over a clear
  wire smi_clr_w  = wr_stat_w & req_w.wdata[ASWC_STAT_SMI_BIT];
  wire smi_stat_d = slp_wr_w | (smi_stat_q & ~smi_clr_w);

  // smi follows the next status value so it rises with the status flag,
  // at the completing edge itself, and not a cycle later
  // clearing the select drops the smi while the status stays set
  // the select doubles as the enable of the smi
  wire smi_d = smi_stat_d & cfg_q.sleep_function_select;

  // the power-on request is taken as synchronous; only its falling edge
  // counts, so a button held low sets the status once and not each cycle
  // wakeup events are levels: an enabled event that stays high while selected keeps
  // setting the status and so wins over every clear while it lasts
  // wake sources: power-on fall always, enabled wakeups only when selected
  wire pwr_fall_w = pwr_prev_q & ~power_on_request_n_in;
  wire wake_evt_w = cfg_q.wake_function_select & (|(wake_event_in & wen_q));
  wire wake_clr_w = wr_stat_w & req_w.wdata[ASWC_STAT_WAK_BIT];
  wire wake_d     = pwr_fall_w | wake_evt_w | (wake_q & ~wake_clr_w);

  // an unmapped word reads zero; the error flag tells software why
  // readback mux, narrow data in the low bits, upper bits zero
  wire [31:0] rd_w =
    hit_cfg_w  ? {30'h0, cfg_q.wake_function_select, cfg_q.sleep_function_select} :
    hit_ctrl_w ? {29'h0, type_q} :
    hit_stat_w ? {30'h0, wake_q, smi_stat_q} :
    hit_wen_w  ? {{(32-WAKE_N){1'b0}}, wen_q} : 32'h0;

  // read data is captured in setup, so the access cycle shows a flop and
  // not the mux; the cost is that a read sees state one cycle old
  // bus answer: ready in the access cycle, so zero wait states
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~mapped_w;   // unmapped address gets an error
      if (setup_w) begin
        prdata_q <= rd_w;                 // captured while address is stable
      end
    end
  end

  // registers written by software only; no hardware event changes them
  // configuration and software-visible state, cleared by reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_q  <= aswc_cfg_type'(ASWC_CFG_RST[1:0]);
      type_q <= ASWC_TYPE_RST;
      wen_q  <= '0;
    end else begin
      cfg_q  <= cfg_d;
      type_q <= type_d;
      if (wr_wen_w) begin
        wen_q <= req_w.wdata[WAKE_N-1:0];
      end
    end
  end

  // flags that hardware sets and software clears, with the output flops
  // the previous power-on level resets high, matching the idle line,
  // so leaving reset with the line high never looks like a fall
  // event flags and outputs
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      smi_stat_q <= 1'b0;
      wake_q     <= 1'b0;
      start_q    <= 1'b0;
      smi_q      <= 1'b0;
      pwr_prev_q <= ASWC_PWR_RST;  // idle high, so reset gives no false fall
    end else begin
      smi_stat_q <= smi_stat_d;
      wake_q     <= wake_d;
      start_q    <= start_d;
      smi_q      <= smi_d;
      pwr_prev_q <= power_on_request_n_in;
    end
  end

  // every output is a flop, so the far side sees no decode glitches
  // outputs straight from flops
  assign prdata_out      = prdata_q;
  assign pready_out      = pready_q;
  assign pslverr_out     = pslverr_q;
  assign sleep_start_out = start_q;
  assign sleep_type_out  = type_q;
  assign smi_out         = smi_q;
  assign wake_status_out = wake_q;

  // checks: all on the one clock, quiet while reset is held
  // each one watches what this block drives, never the bus master
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_sleep_starts: assert property (
    slp_wr_w && !cfg_q.sleep_function_select |=> sleep_start_out ##1 !sleep_start_out)
    else $error("sleep enable write did not start sleep");

  chk_sleep_blocked: assert property (
    sleep_start_out |-> $past(slp_wr_w) && !$past(cfg_q.sleep_function_select))
    else $error("sleep started without an allowed request");

  chk_smi_raised: assert property (
    slp_wr_w && cfg_q.sleep_function_select |=> smi_out && !sleep_start_out)
    else $error("diverted sleep request raised no smi");

  chk_flag_always: assert property (
    slp_wr_w |=> smi_stat_q)
    else $error("smi status not set by sleep enable write");

  chk_smi_gated: assert property (
    smi_out |-> $past(cfg_q.sleep_function_select) && smi_stat_q)
    else $error("smi raised while select was zero");

  chk_wake_fall: assert property (
    $rose(wake_status_out) && !$past(cfg_q.wake_function_select) |-> $past(pwr_fall_w))
    else $error("wake status set without power-on fall");

  chk_wake_event: assert property (
    (cfg_q.wake_function_select && |(wake_event_in & wen_q)) || pwr_fall_w
    |=> wake_status_out)
    else $error("wake source did not set wake status");

  chk_cfg_reserved: assert property (
    pready_out && $past(setup_w && hit_cfg_w) |-> prdata_out[31:2] == 30'h0)
    else $error("reserved config bits read nonzero");

  chk_ready_timing: assert property (
    setup_w |=> pready_out ##1 !pready_out)
    else $error("ready not given in the access cycle");

  chk_start_single: assert property (
    sleep_start_out |=> !sleep_start_out)
    else $error("sleep start lasted more than one cycle");

  chk_type_follow: assert property (
    wr_ctrl_w |=> sleep_type_out == $past(req_w.wdata[2:0]))
    else $error("sleep type did not follow control write");

  chk_smi_sticky: assert property (
    smi_stat_q && !smi_clr_w |=> smi_stat_q)
    else $error("smi status dropped without a clear");

  chk_smi_clear: assert property (
    smi_clr_w && !slp_wr_w |=> !smi_stat_q && !smi_out)
    else $error("smi status survived its clear");

  chk_smi_masked: assert property (
    !cfg_q.sleep_function_select |=> !smi_out)
    else $error("smi raised with select at zero");

  chk_wake_sticky: assert property (
    wake_status_out && !wake_clr_w |=> wake_status_out)
    else $error("wake status dropped without a clear");

  chk_wake_source: assert property (
    $rose(wake_status_out) |-> $past(pwr_fall_w) || $past(wake_evt_w))
    else $error("wake status set with no source");

  chk_wake_clear: assert property (
    wake_clr_w && !pwr_fall_w && !wake_evt_w |=> !wake_status_out)
    else $error("wake status survived its clear");

  chk_err_unmapped: assert property (
    setup_w && !mapped_w |=> pready_out && pslverr_out)
    else $error("unmapped word answered without error");

  chk_err_mapped: assert property (
    setup_w && mapped_w |=> !pslverr_out)
    else $error("mapped word answered with error");

  chk_stat_upper: assert property (
    pready_out && $past(setup_w && hit_stat_w) |-> prdata_out[31:2] == 30'h0)
    else $error("status upper bits read nonzero");

  // main scenarios that the bench is expected to reach
  cov_sleep_go:  cover property (slp_wr_w && !cfg_q.sleep_function_select ##1 sleep_start_out);
  cov_smi_go:    cover property (slp_wr_w && cfg_q.sleep_function_select ##1 smi_out);
  cov_wake_evt:  cover property (wake_evt_w && !pwr_fall_w ##1 wake_status_out);
  cov_err:       cover property (pready_out && pslverr_out);
  cov_wake_fall: cover property (pwr_fall_w ##1 wake_status_out);

endmodule
`default_nettype wire

// ==== tb/aswc_power_ctl.sv ====
`default_nettype none
// far-side power control: presses the power-on request, counts sleep starts
module aswc_power_ctl #(
  parameter int HOLD = 2 // low cycles per press; larger models a slow button
) (
  input  wire logic       clock_in,   // system clock
  input  wire logic       rst_in,     // synchronous reset, high
  input  wire logic       press_in,   // bench command: one press
  input  wire logic       sleep_in,   // sleep start pulse from the block
  output logic            pwr_n_out,  // power-on request, low active
  output logic [7:0]      sleeps_out  // sleep starts seen so far
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hold_q; // remaining low cycles of a press
  // the line idles high as its pull-up would; low only while a press is held
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hold_q <= 4'h0;
      sleeps_out <= 8'h00;
    end else begin
      if (press_in) hold_q <= 4'(HOLD);
      else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
      if (sleep_in) sleeps_out <= sleeps_out + 8'h01;
    end
  end
  assign pwr_n_out = (hold_q == 4'h0);
endmodule
`default_nettype wire

// ==== tb/acpi_sleep_wake_config_test.sv ====
`default_nettype none
module acpi_sleep_wake_config_test
  import aswc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, press = 1'b0;
  logic [7:0]  paddr = 8'h00, wake_ev = 8'h00, en, sleeps;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h485EE9AC;
  logic pready, pslverr, pwr_n, start, smi, wst, er;
  logic [2:0] stype;
  int miscompares = 0, n_tests = 0;
  always #25 clk = ~clk; // 20 mhz
  aswc_top #(.WAKE_N(8)) dut_u (.clock_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .power_on_request_n_in(pwr_n), .wake_event_in(wake_ev), .sleep_start_out(start),
    .sleep_type_out(stype), .smi_out(smi), .wake_status_out(wst));
  aswc_power_ctl #(.HOLD(2)) far_u (.clock_in(clk), .rst_in(rst), .press_in(press),
    .sleep_in(start), .pwr_n_out(pwr_n), .sleeps_out(sleeps));
  // xorshift keeps the random draw repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // configuration readback: the two selects, reserved bits zero
  function automatic logic [31:0] cfg_exp(input logic [31:0] d);
    return {30'h0, d[ASWC_CFG_WAK_BIT], d[ASWC_CFG_SLP_BIT]};
  endfunction
  // one apb transfer; a dead slave is caught by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end
  endtask
  task automatic settle(input int c); // let c edges pass, then sample
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset value, reserved bits, unmapped place
    apb(1'b0, ASWC_CFG_OFF, 32'h0); chk("cfg reset", 32'h0, rd);
    r = rnd() | 32'hFFFFFFFC;
    apb(1'b1, ASWC_CFG_OFF, r); apb(1'b0, ASWC_CFG_OFF, 32'h0);
    chk("cfg reserved", cfg_exp(r), rd);
    apb(1'b0, 8'h10, 32'h0); chk("unmapped err", 32'h1, {31'h0, er});
    $display("test registers done");
    // sleep enable under both selects; status left set at select 0
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ASWC_CFG_OFF, 32'(s));
      settle(2);
      chk("smi stale", 32'(s), {31'h0, smi});
      r = rnd();
      apb(1'b1, ASWC_CTRL_OFF, {24'h0, 5'h10, r[2:0]});
      settle(0);
      chk("start", 32'(1 - s), {31'h0, start});
      chk("smi", 32'(s), {31'h0, smi});
      chk("type", {29'h0, r[2:0]}, {29'h0, stype});
      apb(1'b0, ASWC_STAT_OFF, 32'h0); chk("smi status", 32'h1, rd & 32'h1);
    end
    apb(1'b1, ASWC_STAT_OFF, 32'h1);
    settle(2);
    chk("smi clear", 32'h0, {31'h0, smi});
    chk("sleeps", 32'h1, {24'h0, sleeps});
    $display("test sleep done");
    // wake: enabled event ignored at select 0, counted at select 1
    r = rnd();
    en = r[7:0] | 8'h01;
    apb(1'b1, ASWC_WEN_OFF, {24'h0, en});
    apb(1'b1, ASWC_CFG_OFF, 32'h0);
    wake_ev <= en;
    settle(3);
    chk("wake ev sel0", 32'h0, {31'h0, wst});
    @(posedge clk) press <= 1'b1;
    @(posedge clk) press <= 1'b0;
    settle(3);
    chk("wake fall", 32'h1, {31'h0, wst});
    apb(1'b1, ASWC_STAT_OFF, 32'h2);
    @(posedge clk) wake_ev <= ~en;
    apb(1'b1, ASWC_CFG_OFF, 32'h2);
    settle(3);
    chk("wake disabled", 32'h0, {31'h0, wst});
    @(posedge clk) wake_ev <= en;
    settle(2);
    chk("wake ev sel1", 32'h1, {31'h0, wst});
    $display("test wake done");
    end_of_test();
  end
endmodule
`default_nettype wire
